// ### bench/pmr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmr_host_model (
	input wire logic core_clk,
	output var logic reg_wr,
	output var logic reg_rd,
	output var logic [7:0] reg_addr,
	output var logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Released lines show the inverse so stale values never pass as valid
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rvalid ? reg_rdata : 8'hXX;
	endtask : rd
endmodule : pmr_host_model
`default_nettype wire

// ### bench/pmr_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pmr_regs_assertions
	import pmr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic global_watchdog_lock,
	input wire logic global_lock_write,
	input wire logic measure_start,
	input wire logic measure_converter_one,
	input wire logic pin_disable_permit,
	input wire logic disable_control_lock_flag
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_key(logic [7:0] k);
		reg_wr && reg_addr == OFS_WATCHDOG_DISABLE_UNLOCK_KEY && reg_wdata == k
			&& !global_watchdog_lock && !global_lock_write;
	endsequence
	// Any write or global lock between key bytes breaks the sequence
	sequence s_gap;
		!reg_wr && !global_lock_write;
	endsequence
	sequence s_unlock;
		s_key(KEY_FIRST) ##1 s_gap ##1 s_key(KEY_SECOND) ##1 s_gap ##1 s_key(KEY_THIRD);
	endsequence
	a_unlock_clears: assert property (s_unlock |=> !disable_control_lock_flag)
		else $error("lock flag still set after key sequence");
	a_key_relock: assert property (reg_wr && reg_addr == OFS_WATCHDOG_DISABLE_UNLOCK_KEY
		&& (reg_wdata != KEY_THIRD || global_watchdog_lock) |=> disable_control_lock_flag)
		else $error("key write did not set lock flag");
	a_lock_global: assert property (global_lock_write |=> disable_control_lock_flag)
		else $error("global lock write did not set lock flag");
	a_key_reads_zero: assert property (reg_rd && reg_addr == OFS_WATCHDOG_DISABLE_UNLOCK_KEY
		|=> reg_rvalid && reg_rdata == 8'h00) else $error("key register read not zero");
	a_measure_start: assert property (measure_start
		== $past(reg_wr && reg_addr == OFS_MEASURE_SELECT)) else $error("measure start wrong");
	a_conv_select: assert property (reg_wr && reg_addr == OFS_MEASURE_SELECT
		|=> measure_converter_one == $past(reg_wdata[0])) else $error("converter choice wrong");
	a_permit_locked: assert property (reg_wr && reg_addr == OFS_WATCHDOG_DISABLE_CONTROL
		&& reg_wdata[POS_PERMIT] && (disable_control_lock_flag || global_watchdog_lock)
		&& !pin_disable_permit |=> !pin_disable_permit) else $error("permit set while locked");
	a_high_reserved: assert property (reg_rd && reg_addr == OFS_LOAD_CURRENT_HIGH
		|=> reg_rdata[7:1] == 7'h00) else $error("reserved load bits not zero");
	a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
	a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00) else $error("rdata not idle");
endmodule : pmr_regs_assertions
bind pmr_regs pmr_regs_assertions u_chk (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_rdata, .reg_rvalid, .global_watchdog_lock, .global_lock_write,
	.measure_start, .measure_converter_one, .pin_disable_permit, .disable_control_lock_flag);
`default_nettype wire

// ### bench/pmr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pmr_regs_tb
	import pmr_pkg::*;
;
	logic core_clk = 0, rst_n = 0, reg_wr, reg_rd, reg_rvalid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, o, rd;
	logic otp_load = 0, otp_boost_frequency_choice = 0, otp_pin_disable_permit = 0;
	logic otp_single_error = 0, otp_double_error = 0, measure_done = 0;
	logic global_watchdog_lock = 0, global_lock_write = 0;
	logic [1:0] otp_stepdown_frequency_choice = 0, otp_boost_current_limit = 0;
	logic [8:0] measure_value = 0, v;
	logic measure_start, measure_converter_one, boost_frequency_choice;
	logic pin_disable_permit, disable_control_lock_flag;
	logic [1:0] stepdown_frequency_choice, boost_current_limit;
	int err_total = 0, n_tests = 0;
	always #50 core_clk = ~core_clk;
	pmr_host_model host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_rvalid);
	pmr_regs dut (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_rvalid, .otp_load, .otp_stepdown_frequency_choice, .otp_boost_frequency_choice,
		.otp_boost_current_limit, .otp_pin_disable_permit, .otp_single_error,
		.otp_double_error, .measure_done, .measure_value, .global_watchdog_lock,
		.global_lock_write, .measure_start, .measure_converter_one, .stepdown_frequency_choice,
		.boost_frequency_choice, .boost_current_limit, .pin_disable_permit,
		.disable_control_lock_flag);
	function automatic logic [7:0] exp_freq(input logic [7:0] w, input logic [7:0] img);
		return {w[7:3], img[2:0]};
	endfunction : exp_freq
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task key3;
		host.wr(OFS_WATCHDOG_DISABLE_UNLOCK_KEY, KEY_FIRST);
		host.wr(OFS_WATCHDOG_DISABLE_UNLOCK_KEY, KEY_SECOND);
		host.wr(OFS_WATCHDOG_DISABLE_UNLOCK_KEY, KEY_THIRD);
	endtask : key3
	// Whole run is under two hundred cycles; generous margin
	initial begin
		#(100 * 5000);
		err_total++;
		conclude();
	end
	initial begin
		void'($urandom(59492));
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		host.rd(OFS_WATCHDOG_DISABLE_CONTROL, rd);
		chk(rd, 8'h02);
		for (int a = 8'h2E; a <= 8'h34; a++) begin
			host.rd(a[7:0], rd);
			chk(rd, RST_BYTE);
		end
		host.rd(8'hF0, rd);
		chk(rd, 8'h00);
		repeat (4) begin
			o = 8'($urandom);
			@(posedge core_clk);
			otp_load <= 1'b1;
			{otp_pin_disable_permit, otp_double_error, otp_single_error, otp_boost_current_limit,
				otp_boost_frequency_choice, otp_stepdown_frequency_choice} <= o;
			@(posedge core_clk);
			otp_load <= 1'b0;
			d = 8'($urandom);
			host.wr(OFS_SWITCHING_FREQUENCY_SELECT, d);
			host.rd(OFS_SWITCHING_FREQUENCY_SELECT, rd);
			chk(rd, exp_freq(d, o));
			host.rd(OFS_OTP_ECC_STATUS, rd);
			chk(rd, {6'h00, o[6:5]});
			chk({2'h0, pin_disable_permit, boost_current_limit, boost_frequency_choice,
				stepdown_frequency_choice}, {2'h0, o[7], o[4:0]});
		end
		for (int c = 0; c < 4; c++) begin
			d = {6'($urandom), c[1:0]};
			host.wr(OFS_BOOST_CURRENT_LIMIT_CONTROL, d);
			host.rd(OFS_BOOST_CURRENT_LIMIT_CONTROL, rd);
			chk(rd, d);
			chk({6'h00, boost_current_limit}, {6'h00, c[1:0]});
			host.wr(OFS_MEASURE_SELECT, {6'h00, c[1:0]});
			chk({7'h00, measure_converter_one}, {7'h00, c[0]});
			chk({7'h00, measure_start}, 8'h01);
		end
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 9'h1FF : 9'($urandom);
			@(posedge core_clk);
			measure_done <= 1'b1;
			measure_value <= v;
			@(posedge core_clk);
			measure_done <= 1'b0;
			host.wr(OFS_LOAD_CURRENT_LOW, ~v[7:0]);
			host.wr(OFS_LOAD_CURRENT_HIGH, 8'hFF);
			host.rd(OFS_LOAD_CURRENT_HIGH, rd);
			chk(rd, {7'h00, v[8]});
			host.rd(OFS_LOAD_CURRENT_LOW, rd);
			chk(rd, v[7:0]);
		end
		@(posedge core_clk);
		global_watchdog_lock <= 1'b1;
		key3();
		chk({7'h00, disable_control_lock_flag}, 8'h01);
		@(posedge core_clk);
		global_watchdog_lock <= 1'b0;
		host.wr(OFS_WATCHDOG_DISABLE_UNLOCK_KEY, KEY_FIRST);
		host.wr(OFS_LOAD_CURRENT_LOW, 8'h00);
		host.wr(OFS_WATCHDOG_DISABLE_UNLOCK_KEY, KEY_SECOND);
		host.wr(OFS_WATCHDOG_DISABLE_UNLOCK_KEY, KEY_THIRD);
		chk({7'h00, disable_control_lock_flag}, 8'h01);
		key3();
		chk({7'h00, disable_control_lock_flag}, 8'h00);
		host.rd(OFS_WATCHDOG_DISABLE_UNLOCK_KEY, rd);
		chk(rd, 8'h00);
		host.wr(OFS_WATCHDOG_DISABLE_CONTROL, 8'h01);
		host.rd(OFS_WATCHDOG_DISABLE_CONTROL, rd);
		chk(rd, 8'h01);
		host.wr(OFS_WATCHDOG_DISABLE_CONTROL, 8'h00);
		host.wr(OFS_WATCHDOG_DISABLE_UNLOCK_KEY, 8'($urandom));
		host.wr(OFS_WATCHDOG_DISABLE_CONTROL, 8'h01);
		chk({6'h00, disable_control_lock_flag, pin_disable_permit}, 8'h02);
		key3();
		@(posedge core_clk);
		global_watchdog_lock <= 1'b1;
		host.wr(OFS_WATCHDOG_DISABLE_CONTROL, 8'h01);
		chk({6'h00, disable_control_lock_flag, pin_disable_permit}, 8'h00);
		@(posedge core_clk);
		global_watchdog_lock <= 1'b0;
		global_lock_write <= 1'b1;
		@(posedge core_clk);
		global_lock_write <= 1'b0;
		#1;
		chk({7'h00, disable_control_lock_flag}, 8'h01);
		@(posedge core_clk);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		host.rd(OFS_WATCHDOG_DISABLE_CONTROL, rd);
		chk(rd, 8'h02);
		conclude();
	end
endmodule : pmr_regs_tb
`default_nettype wire

// ### include/pmr_pkg.sv
`default_nettype none
package pmr_pkg;
	// Register offsets
	localparam logic [7:0] OFS_MEASURE_SELECT = 8'h2E;
	localparam logic [7:0] OFS_LOAD_CURRENT_HIGH = 8'h2F;
	localparam logic [7:0] OFS_LOAD_CURRENT_LOW = 8'h30;
	localparam logic [7:0] OFS_SWITCHING_FREQUENCY_SELECT = 8'h31;
	localparam logic [7:0] OFS_BOOST_CURRENT_LIMIT_CONTROL = 8'h32;
	localparam logic [7:0] OFS_OTP_ECC_STATUS = 8'h33;
	localparam logic [7:0] OFS_WATCHDOG_DISABLE_UNLOCK_KEY = 8'h34;
	localparam logic [7:0] OFS_WATCHDOG_DISABLE_CONTROL = 8'h35;

	// Field positions
	localparam int unsigned POS_LOAD_MSB = 0;
	localparam int unsigned POS_STEPDOWN_FREQ = 0;
	localparam int unsigned POS_BOOST_FREQ = 2;
	localparam int unsigned POS_BOOST_LIMIT = 0;
	localparam int unsigned POS_SINGLE_ERROR = 0;
	localparam int unsigned POS_DOUBLE_ERROR = 1;
	localparam int unsigned POS_PERMIT = 0;
	localparam int unsigned POS_LOCK = 1;
	localparam int unsigned POS_SELECT = 0;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_LOCK = 1'b1;
	localparam logic [1:0] RST_FIELD2 = 2'h0;
	localparam logic RST_BIT = 1'b0;
	localparam logic [8:0] RST_LOAD_CURRENT = 9'h000;

	// Unlock key bytes, in order
	localparam logic [7:0] KEY_FIRST = 8'h87;
	localparam logic [7:0] KEY_SECOND = 8'h65;
	localparam logic [7:0] KEY_THIRD = 8'h1B;

	typedef enum logic [2:0] {
		PMR_KEY_IDLE = 3'b001,
		PMR_KEY_GOT1 = 3'b010,
		PMR_KEY_GOT2 = 3'b100
	} pmr_key_state_e;
endpackage : pmr_pkg
`default_nettype wire

// ### logic/pmr_regs.sv
// Operation
// - Bit 0 of the upper load-current register shows bit 8 of the averaged load current, 20 mA per count up to 10 A.
// - The lower load-current register shows bits 7 to 0 of the averaged load current, read-only.
// - Frequency register shows the step-down frequency code in bits 1-0 and the boost frequency in bit 2, both loaded from OTP.
// - The writable two-bit boost current limit selects 1.0, 1.4, 1.9 or 2.8 A and defaults from OTP.
// - Bit 1 of the ECC status reads 1 when the OTP read found an uncorrectable double error, else 0.
// - Bit 0 of the ECC status reads 1 when the OTP read corrected a single error, else 0.
// - Writing 0x87, 0x65, 0x1B in three consecutive writes to the key register clears the lock flag while the global watchdog lock is 0.
// - Reading the key register always returns zero.
// - Writing the select register starts a measurement on converter 0 for codes 0 and 2, converter 1 for 1 and 3.
// - The lock flag sits in bit 1 of the control register, reads 1 when locked and resets to 1.
// - The permit bit lets the disable pin turn the watchdog off; a register write sets it to 1 only when both locks are 0, but an OTP load sets it regardless.
`timescale 1ns/1ns
`default_nettype none
module pmr_regs
	import pmr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic otp_load,
	input wire logic [1:0] otp_stepdown_frequency_choice,
	input wire logic otp_boost_frequency_choice,
	input wire logic [1:0] otp_boost_current_limit,
	input wire logic otp_pin_disable_permit,
	input wire logic otp_single_error,
	input wire logic otp_double_error,
	input wire logic measure_done,
	input wire logic [8:0] measure_value,
	input wire logic global_watchdog_lock,
	input wire logic global_lock_write,
	output logic measure_start,
	output logic measure_converter_one,
	output logic [1:0] stepdown_frequency_choice,
	output logic boost_frequency_choice,
	output logic [1:0] boost_current_limit,
	output logic pin_disable_permit,
	output logic disable_control_lock_flag
);
	logic [8:0] load_current;
	logic [1:0] measure_code;
	logic [5:0] select_reserved;
	logic [4:0] freq_reserved;
	logic [5:0] limit_reserved;
	logic [5:0] control_reserved;
	logic single_error_flag;
	logic double_error_flag;
	logic [8:0] next_load_current;
	logic [1:0] next_measure_code;
	logic [5:0] next_select_reserved;
	logic [4:0] next_freq_reserved;
	logic [5:0] next_limit_reserved;
	logic [5:0] next_control_reserved;
	logic next_single_error_flag;
	logic next_double_error_flag;
	logic [1:0] next_stepdown_frequency_choice;
	logic next_boost_frequency_choice;
	logic [1:0] next_boost_current_limit;
	logic next_pin_disable_permit;
	logic next_disable_control_lock_flag;
	logic next_measure_start;
	logic next_measure_converter_one;
	logic [7:0] next_reg_rdata;
	logic next_reg_rvalid;
	logic wr_select;
	logic wr_freq;
	logic wr_limit;
	logic wr_key;
	logic wr_control;
	logic wr_other;
	logic key_complete;

	assign wr_select = reg_wr && (reg_addr == OFS_MEASURE_SELECT);
	assign wr_freq = reg_wr && (reg_addr == OFS_SWITCHING_FREQUENCY_SELECT);
	assign wr_limit = reg_wr && (reg_addr == OFS_BOOST_CURRENT_LIMIT_CONTROL);
	assign wr_key = reg_wr && (reg_addr == OFS_WATCHDOG_DISABLE_UNLOCK_KEY);
	assign wr_control = reg_wr && (reg_addr == OFS_WATCHDOG_DISABLE_CONTROL);
	assign wr_other = reg_wr && !wr_key;

	pmr_unlock_seq u_unlock_seq (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.key_write(wr_key),
		.other_write(wr_other),
		.global_lock_write(global_lock_write),
		.key_data(reg_wdata),
		.global_watchdog_lock(global_watchdog_lock),
		.key_complete(key_complete)
	);

	always_comb begin
		next_load_current = load_current;
		next_measure_code = measure_code;
		next_select_reserved = select_reserved;
		next_freq_reserved = freq_reserved;
		next_limit_reserved = limit_reserved;
		next_control_reserved = control_reserved;
		next_single_error_flag = single_error_flag;
		next_double_error_flag = double_error_flag;
		next_stepdown_frequency_choice = stepdown_frequency_choice;
		next_boost_frequency_choice = boost_frequency_choice;
		next_boost_current_limit = boost_current_limit;
		next_pin_disable_permit = pin_disable_permit;
		next_disable_control_lock_flag = disable_control_lock_flag;
		next_measure_start = 1'b0;
		next_measure_converter_one = measure_converter_one;

		if (measure_done) begin
			next_load_current = measure_value;
		end
		// OTP image overrides defaults; status flags follow each OTP read
		if (otp_load) begin
			next_stepdown_frequency_choice = otp_stepdown_frequency_choice;
			next_boost_frequency_choice = otp_boost_frequency_choice;
			next_boost_current_limit = otp_boost_current_limit;
			next_pin_disable_permit = otp_pin_disable_permit;
			next_single_error_flag = otp_single_error;
			next_double_error_flag = otp_double_error;
		end

		if (wr_select) begin
			next_measure_code = reg_wdata[POS_SELECT +: 2];
			next_select_reserved = reg_wdata[7:2];
			next_measure_start = 1'b1;
			next_measure_converter_one = reg_wdata[POS_SELECT];
		end
		// Read-only frequency fields keep their value on writes
		if (wr_freq) begin
			next_freq_reserved = reg_wdata[7:3];
		end
		if (wr_limit) begin
			next_boost_current_limit = reg_wdata[POS_BOOST_LIMIT +: 2];
			next_limit_reserved = reg_wdata[7:2];
		end
		if (wr_control) begin
			next_control_reserved = reg_wdata[7:2];
			// Clearing is always allowed; setting needs both locks open
			if (!reg_wdata[POS_PERMIT] ||
				(!global_watchdog_lock && !disable_control_lock_flag)) begin
				next_pin_disable_permit = reg_wdata[POS_PERMIT];
			end
		end

		if (global_lock_write || (wr_key && !key_complete)) begin
			next_disable_control_lock_flag = 1'b1;
		end else if (key_complete) begin
			next_disable_control_lock_flag = 1'b0;
		end
	end

	always_comb begin
		next_reg_rvalid = reg_rd;
		next_reg_rdata = RST_BYTE;
		if (reg_rd) begin
			case (reg_addr)
				OFS_MEASURE_SELECT: begin
					next_reg_rdata = {select_reserved, measure_code};
				end
				OFS_LOAD_CURRENT_HIGH: begin
					next_reg_rdata[POS_LOAD_MSB] = load_current[8];
				end
				OFS_LOAD_CURRENT_LOW: begin
					next_reg_rdata = load_current[7:0];
				end
				OFS_SWITCHING_FREQUENCY_SELECT: begin
					next_reg_rdata = {freq_reserved, 3'h0};
					next_reg_rdata[POS_BOOST_FREQ] = boost_frequency_choice;
					next_reg_rdata[POS_STEPDOWN_FREQ +: 2] = stepdown_frequency_choice;
				end
				OFS_BOOST_CURRENT_LIMIT_CONTROL: begin
					next_reg_rdata = {limit_reserved, boost_current_limit};
				end
				OFS_OTP_ECC_STATUS: begin
					next_reg_rdata[POS_DOUBLE_ERROR] = double_error_flag;
					next_reg_rdata[POS_SINGLE_ERROR] = single_error_flag;
				end
				OFS_WATCHDOG_DISABLE_UNLOCK_KEY: begin
					next_reg_rdata = RST_BYTE;
				end
				OFS_WATCHDOG_DISABLE_CONTROL: begin
					next_reg_rdata = {control_reserved, 2'h0};
					next_reg_rdata[POS_LOCK] = disable_control_lock_flag;
					next_reg_rdata[POS_PERMIT] = pin_disable_permit;
				end
				default: begin
					next_reg_rdata = RST_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			load_current <= RST_LOAD_CURRENT;
			measure_code <= RST_FIELD2;
			select_reserved <= RST_BYTE[5:0];
			freq_reserved <= RST_BYTE[4:0];
			limit_reserved <= RST_BYTE[5:0];
			control_reserved <= RST_BYTE[5:0];
			single_error_flag <= RST_BIT;
			double_error_flag <= RST_BIT;
			stepdown_frequency_choice <= RST_FIELD2;
			boost_frequency_choice <= RST_BIT;
			boost_current_limit <= RST_FIELD2;
			pin_disable_permit <= RST_BIT;
			disable_control_lock_flag <= RST_LOCK;
			measure_start <= RST_BIT;
			measure_converter_one <= RST_BIT;
			reg_rdata <= RST_BYTE;
			reg_rvalid <= RST_BIT;
		end else begin
			load_current <= next_load_current;
			measure_code <= next_measure_code;
			select_reserved <= next_select_reserved;
			freq_reserved <= next_freq_reserved;
			limit_reserved <= next_limit_reserved;
			control_reserved <= next_control_reserved;
			single_error_flag <= next_single_error_flag;
			double_error_flag <= next_double_error_flag;
			stepdown_frequency_choice <= next_stepdown_frequency_choice;
			boost_frequency_choice <= next_boost_frequency_choice;
			boost_current_limit <= next_boost_current_limit;
			pin_disable_permit <= next_pin_disable_permit;
			disable_control_lock_flag <= next_disable_control_lock_flag;
			measure_start <= next_measure_start;
			measure_converter_one <= next_measure_converter_one;
			reg_rdata <= next_reg_rdata;
			reg_rvalid <= next_reg_rvalid;
		end
	end
endmodule : pmr_regs
`default_nettype wire

// ### logic/pmr_unlock_seq.sv
`timescale 1ns/1ns
`default_nettype none
module pmr_unlock_seq
	import pmr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic key_write,
	input wire logic other_write,
	input wire logic global_lock_write,
	input wire logic [7:0] key_data,
	input wire logic global_watchdog_lock,
	output logic key_complete
);
	pmr_key_state_e state;
	pmr_key_state_e next_state;

	always_comb begin
		next_state = state;
		key_complete = 1'b0;
		if (global_lock_write || other_write) begin
			next_state = PMR_KEY_IDLE;
		end else if (key_write) begin
			next_state = PMR_KEY_IDLE;
			if (!global_watchdog_lock) begin
				case (state)
					PMR_KEY_IDLE: begin
						if (key_data == KEY_FIRST) begin
							next_state = PMR_KEY_GOT1;
						end
					end
					PMR_KEY_GOT1: begin
						if (key_data == KEY_SECOND) begin
							next_state = PMR_KEY_GOT2;
						end else if (key_data == KEY_FIRST) begin
							next_state = PMR_KEY_GOT1;
						end
					end
					PMR_KEY_GOT2: begin
						if (key_data == KEY_THIRD) begin
							key_complete = 1'b1;
						end else if (key_data == KEY_FIRST) begin
							next_state = PMR_KEY_GOT1;
						end
					end
					default: begin
						next_state = PMR_KEY_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= PMR_KEY_IDLE;
		end else begin
			state <= next_state;
		end
	end
endmodule : pmr_unlock_seq
`default_nettype wire
